// [rtl/two_wire_pkg.sv]
// ==========================================================
// Operation
// - one eight-bit data register carries every data byte sent or received
// - debounce code 00 none, 01 two clocks, 10 and 11 four clocks
// - enable 1 gives pins to the bus; enable 0 switches the interface off
// - control zero bits 7 to 4 and bit 0 read back as zero
// - transfer complete reads 0 while shifting, sets after 8 bits with interrupt; in receive the code keeps it at 1 until the data register is read
// - a start condition clears transfer complete
// - reading a received byte clears transfer complete until the next byte
// - a stop condition sets transfer complete
// - address match reads 1 on own address, 0 otherwise
// - bus busy sets on start and clears on stop
// - direction select 0 makes a receiver, 1 a transmitter
// - after eight received data bits the ninth clock carries the transmit ack bit
// - read/write status holds the direction bit of a matched address
// - no ack from the master stops the transmitter and frees the data line
// - selected when the seven address bits match own address bits 7 to 1
// - debounce counts system clocks and guards the incoming serial clock
package two_wire_pkg;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_OWN = 8'h0c;
  localparam logic [7:0] ADDR_TMO = 8'h10;
  localparam logic [7:0] ADDR_IST = 8'h14;
  localparam logic [7:0] ADDR_IMASK = 8'h18;

  // ==========================================================
  // control zero fields
  localparam int C0_EN = 1;
  localparam int C0_DBNC_LO = 2;
  localparam int C0_DBNC_HI = 3;

  // ==========================================================
  // control/status one fields
  localparam int C1_TCF = 7;
  localparam int C1_AMATCH = 6;
  localparam int C1_BUSY = 5;
  localparam int C1_HTX = 4;
  localparam int C1_TXAK = 3;
  localparam int C1_SRW = 2;
  localparam int C1_AMWU = 1;
  localparam int C1_RXAK = 0;

  // ==========================================================
  // interrupt status bits
  localparam int IRQ_BYTE = 0;
  localparam int IRQ_MATCH = 1;
  localparam int IRQ_STOP = 2;
  localparam int IRQ_W = 3;

  // ==========================================================
  // reset values and counts
  localparam logic [7:0] CTRL1_RST = 8'h81;
  localparam logic [1:0] LINE_IDLE = 2'b11;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_ACK = 4'h9;
  localparam logic [2:0] DBNC_TWO = 3'h2;
  localparam logic [2:0] DBNC_FOUR = 3'h4;
  localparam logic [1:0] DBNC_OFF = 2'b00;
  localparam logic [1:0] DBNC_SEL2 = 2'b01;

  typedef enum logic [6:0] {
    st_idle = 7'b000_0001,
    st_addr = 7'b000_0010,
    st_ack_a = 7'b000_0100,
    st_rx = 7'b000_1000,
    st_ack_rx = 7'b001_0000,
    st_tx = 7'b010_0000,
    st_ack_tx = 7'b100_0000
  } state_t;

endpackage : two_wire_pkg

// [rtl/filt_if.sv]
interface filt_if;
  logic [1:0] sel;
  logic scl;
  logic sda;
  modport filt (input sel, output scl, output sda);
  modport core (output sel, input scl, input sda);
endinterface : filt_if

// [rtl/line_filter.sv]
module line_filter
  import two_wire_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  filt_if.filt f
);

  // ==========================================================
  // synchroniser and debounce, bit 0 clock, bit 1 data
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] out_q;
  logic [2:0] cnt_q [2];

  function automatic logic [2:0] dbnc_len(input logic [1:0] sel);
    if (sel == DBNC_SEL2) begin
      return DBNC_TWO;
    end
    return DBNC_FOUR;
  endfunction : dbnc_len

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= LINE_IDLE;
      s2_q <= LINE_IDLE;
    end else begin
      s1_q <= {sda_i, scl_i};
      s2_q <= s1_q;
    end
  end

  // counter clears on any bounce back, so with codes 01 to 11 a glitch shorter than the count never passes
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_i) begin
        out_q[i] <= LINE_IDLE[i];
        cnt_q[i] <= 3'h0;
      end else if (f.sel == DBNC_OFF) begin
        out_q[i] <= s2_q[i];
        cnt_q[i] <= 3'h0;
      end else if (s2_q[i] == out_q[i]) begin
        cnt_q[i] <= 3'h0;
      end else if (cnt_q[i] >= dbnc_len(f.sel) - 3'h1) begin
        out_q[i] <= s2_q[i];
        cnt_q[i] <= 3'h0;
      end else begin
        cnt_q[i] <= cnt_q[i] + 3'h1;
      end
    end
  end

  assign f.scl = out_q[0];
  assign f.sda = out_q[1];

  // ==========================================================
  // checks
  dbnc_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($changed(out_q[0]) && f.sel == DBNC_SEL2 && $past(f.sel) == DBNC_SEL2
      && $past(f.sel, 2) == DBNC_SEL2)
    |-> ($past(s2_q[0]) == out_q[0] && $past(s2_q[0], 2) == out_q[0]))
    else $error("scl passed before two stable clocks");

  dbnc_four_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($changed(out_q[0]) && f.sel[1] && $past(f.sel[1]) && $past(f.sel[1], 2)
      && $past(f.sel[1], 3) && $past(f.sel[1], 4))
    |-> ($past(s2_q[0]) == out_q[0] && $past(s2_q[0], 2) == out_q[0]
      && $past(s2_q[0], 3) == out_q[0] && $past(s2_q[0], 4) == out_q[0]))
    else $error("scl passed before four stable clocks");

endmodule : line_filter

// [rtl/two_wire_slave.sv]
// The register offsets and the Wishbone slave port were left to the implementer.
module two_wire_slave
  import two_wire_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic pins_i2c_o,
  output logic irq_o
);

  // ==========================================================
  // input filter
  filt_if fif ();

  line_filter u_filt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .f(fif.filt)
  );

  // ==========================================================
  // registers
  logic en_q;
  logic [1:0] dbnc_q;
  logic tcf_q;
  logic amatch_q;
  logic busy_q;
  logic htx_q;
  logic txak_q;
  logic srw_q;
  logic amwu_q;
  logic rxak_q;
  logic [7:0] data_q;
  logic [7:1] own_q;
  logic [7:0] tmo_q;
  logic [IRQ_W-1:0] ist_q;
  logic [IRQ_W-1:0] imask_q;
  state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic drive_q;
  logic scl_p_q;
  logic sda_p_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] rmux;

  assign fif.sel = dbnc_q;

  // ==========================================================
  // bus conditions from the filtered lines
  wire scl_f = fif.scl;
  wire sda_f = fif.sda;
  wire rise_ev = en_q && scl_f && !scl_p_q;
  wire fall_ev = en_q && !scl_f && scl_p_q;
  wire start_ev = en_q && scl_f && scl_p_q && sda_p_q && !sda_f;
  wire stop_ev = en_q && scl_f && scl_p_q && !sda_p_q && sda_f;
  wire byte_end = fall_ev && cnt_q == BITS_BYTE;
  wire ack_end = fall_ev && cnt_q == BITS_ACK;
  wire addr_hit = sh_q[7:1] == own_q[7:1];
  wire in_addr = state_q == st_addr;
  wire in_rx = state_q == st_rx;
  wire in_tx = state_q == st_tx;
  wire in_ack_a = state_q == st_ack_a;
  wire in_ack_rx = state_q == st_ack_rx;
  wire in_ack_tx = state_q == st_ack_tx;
  wire match_ev = byte_end && in_addr && addr_hit;
  wire rx_done = byte_end && in_rx;
  wire tx_done = byte_end && in_tx;
  wire byte_ev = match_ev || rx_done || tx_done;
  wire tx_load = ack_end && ((in_ack_a && htx_q) || (in_ack_tx && !rxak_q));
  wire rx_go = ack_end && ((in_ack_a && !htx_q) || in_ack_rx);

  // ==========================================================
  // wishbone decode, one wait state
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr = req && wb_we_i && wb_sel_i[0];
  wire rd = req && !wb_we_i;
  wire a_c0 = wb_adr_i == ADDR_CTRL0;
  wire a_c1 = wb_adr_i == ADDR_CTRL1;
  wire a_dat = wb_adr_i == ADDR_DATA;
  wire a_own = wb_adr_i == ADDR_OWN;
  wire a_tmo = wb_adr_i == ADDR_TMO;
  wire a_ist = wb_adr_i == ADDR_IST;
  wire a_msk = wb_adr_i == ADDR_IMASK;
  wire rd_dat = rd && a_dat;
  wire [7:0] wd = wb_dat_i[7:0];

  // ==========================================================
  // transfer complete: set wins over every clear
  wire tcf_set = byte_ev || stop_ev;
  wire tcf_clr = start_ev || rd_dat || tx_load;
  wire tcf_d = tcf_set || (tcf_q && !tcf_clr);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tcf_q <= CTRL1_RST[C1_TCF];
    end else begin
      tcf_q <= tcf_d;
    end
  end

  // ==========================================================
  // status flags, software cannot write them
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_q) begin
      busy_q <= 1'b0;
    end else if (start_ev) begin
      busy_q <= 1'b1;
    end else if (stop_ev) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      amatch_q <= CTRL1_RST[C1_AMATCH];
      srw_q <= CTRL1_RST[C1_SRW];
    end else if (match_ev) begin
      amatch_q <= 1'b1;
      srw_q <= sh_q[0];
    end else if (start_ev || (byte_end && in_addr)) begin
      amatch_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxak_q <= CTRL1_RST[C1_RXAK];
    end else if (rise_ev && in_ack_tx) begin
      rxak_q <= sda_f;
    end
  end

  // ==========================================================
  // software controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      dbnc_q <= DBNC_OFF;
      htx_q <= CTRL1_RST[C1_HTX];
      txak_q <= CTRL1_RST[C1_TXAK];
      amwu_q <= CTRL1_RST[C1_AMWU];
      own_q <= 7'h00;
      tmo_q <= 8'h00;
      imask_q <= '0;
    end else if (wr) begin
      if (a_c0) begin
        en_q <= wd[C0_EN];
        dbnc_q <= wd[C0_DBNC_HI:C0_DBNC_LO];
      end else if (a_c1) begin
        htx_q <= wd[C1_HTX];
        txak_q <= wd[C1_TXAK];
        amwu_q <= wd[C1_AMWU];
      end else if (a_own) begin
        own_q <= wd[7:1];
      end else if (a_tmo) begin
        tmo_q <= wd;
      end else if (a_msk) begin
        imask_q <= wd[IRQ_W-1:0];
      end
    end
  end

  // received byte beats a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= 8'h00;
    end else if (rx_done) begin
      data_q <= sh_q;
    end else if (wr && a_dat) begin
      data_q <= wd;
    end
  end

  // ==========================================================
  // serial engine; no clock stretching, software must keep pace
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_p_q <= LINE_IDLE[0];
      sda_p_q <= LINE_IDLE[1];
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_q) begin
      state_q <= st_idle;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      drive_q <= 1'b0;
    end else if (start_ev) begin
      state_q <= st_addr;
      cnt_q <= 4'h0;
      drive_q <= 1'b0;
    end else if (stop_ev) begin
      state_q <= st_idle;
      drive_q <= 1'b0;
    end else if (rise_ev && state_q != st_idle) begin
      cnt_q <= cnt_q + 4'h1;
      if (!in_tx) begin
        sh_q <= {sh_q[6:0], sda_f};
      end
    end else if (fall_ev) begin
      case (state_q)
        st_addr: begin
          if (byte_end) begin
            state_q <= addr_hit ? st_ack_a : st_idle;
            drive_q <= addr_hit;
          end
        end
        st_rx: begin
          if (byte_end) begin
            state_q <= st_ack_rx;
            drive_q <= !txak_q;
          end
        end
        st_tx: begin
          if (byte_end) begin
            state_q <= st_ack_tx;
            drive_q <= 1'b0;
          end else begin
            drive_q <= !sh_q[7];
            sh_q <= {sh_q[6:0], 1'b0};
          end
        end
        st_ack_a, st_ack_rx, st_ack_tx: begin
          if (ack_end) begin
            cnt_q <= 4'h0;
            if (tx_load) begin
              state_q <= st_tx;
              drive_q <= !data_q[7];
              sh_q <= {data_q[6:0], 1'b0};
            end else if (rx_go) begin
              state_q <= st_rx;
              drive_q <= 1'b0;
            end else begin
              state_q <= st_idle;
              drive_q <= 1'b0;
            end
          end
        end
        default: begin
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = drive_q && en_q;
  assign pins_i2c_o = en_q;

  // ==========================================================
  // interrupts: sticky, cleared by reading, set wins
  wire [IRQ_W-1:0] ev = {stop_ev, match_ev, byte_ev};
  wire ist_rd = rd && a_ist;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_q <= '0;
    end else begin
      ist_q <= ev | (ist_rd ? '0 : ist_q);
    end
  end

  assign irq_o = |(ist_q & imask_q);

  // ==========================================================
  // read mux; unmapped reads zero
  wire [7:0] c0_rd = {4'h0, dbnc_q, en_q, 1'b0};
  wire [7:0] c1_rd = {tcf_q, amatch_q, busy_q, htx_q, txak_q, srw_q, amwu_q, rxak_q};

  always_comb begin
    if (a_c0) begin
      rmux = c0_rd;
    end else if (a_c1) begin
      rmux = c1_rd;
    end else if (a_dat) begin
      rmux = data_q;
    end else if (a_own) begin
      rmux = {own_q, 1'b0};
    end else if (a_tmo) begin
      rmux = tmo_q;
    end else if (a_ist) begin
      rmux = {5'h00, ist_q};
    end else if (a_msk) begin
      rmux = {5'h00, imask_q};
    end else begin
      rmux = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      rdat_q <= rd ? {24'h00_0000, rmux} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ==========================================================
  // checks
  start_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_ev |=> (!tcf_q && busy_q && state_q == st_addr))
    else $error("start did not clear complete flag");

  stop_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_ev |=> (tcf_q && !busy_q))
    else $error("stop did not set complete flag");

  read_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_dat && !tcf_set) |=> !tcf_q)
    else $error("data read did not clear complete flag");

  byte_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    byte_ev |=> (tcf_q && ist_q[IRQ_BYTE]))
    else $error("byte end did not set flag and interrupt");

  ctrl_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && !wb_we_i && a_c0)
    |-> (wb_dat_o[31:4] == 28'h000_0000 && !wb_dat_o[0]))
    else $error("unimplemented control bits read nonzero");

  ack_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(in_ack_rx) |-> (sda_oe_o == !$past(txak_q)))
    else $error("ninth clock does not carry transmit ack");

  addr_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(amatch_q) |-> ($past(addr_hit) && srw_q == $past(sh_q[0])))
    else $error("address match without own address");

  nack_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_end && in_ack_tx && rxak_q) |=> (!sda_oe_o && state_q == st_idle))
    else $error("transmitter kept line after missing ack");

  dir_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(in_tx) && $past(in_ack_a)) |-> $past(htx_q))
    else $error("transmit entered without direction select");

  off_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_q |=> (state_q == st_idle && !busy_q && !sda_oe_o))
    else $error("disabled interface still active");

  ro_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && a_c1 && !tcf_set && !tcf_clr && !start_ev && !stop_ev)
    |=> ($stable(tcf_q) && $stable(busy_q)))
    else $error("software write moved a status flag");

  match_c: cover property (@(posedge clk_i) disable iff (rst_i) match_ev);
  rx_byte_c: cover property (@(posedge clk_i) disable iff (rst_i) rx_done);
  tx_nack_c: cover property (@(posedge clk_i) disable iff (rst_i)
    ack_end && in_ack_tx && rxak_q);
  irq_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));

endmodule : two_wire_slave

// [testbench/wire_master.sv]
module wire_master (
  input wire logic clk_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // line level
  // pull-up: low only while someone pulls it
  wire logic line = sda_o & ~sda_oe_i;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // ==========================================================
  // framing; clock stands high between frames
  task automatic start();
    sda_o <= 1'b1;
    tick(4);
    scl_o <= 1'b1;
    tick(8);
    sda_o <= 1'b0;
    tick(8);
    scl_o <= 1'b0;
  endtask : start

  task automatic stop();
    tick(2);
    sda_o <= 1'b0;
    tick(8);
    scl_o <= 1'b1;
    tick(8);
    sda_o <= 1'b1;
    tick(8);
  endtask : stop

  // one clock high pulse, shorter than any debounce
  task automatic glitch();
    scl_o <= 1'b1;
    tick(1);
    scl_o <= 1'b0;
    tick(4);
  endtask : glitch

  // ==========================================================
  // one bit: 10 clocks low, 6 high, an 80 ns period
  // data moves 2 clocks after the fall to stay clear of the edge
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    sda_o <= b;
    tick(8);
    scl_o <= 1'b1;
    tick(3);
    r = line;
    tick(3);
    scl_o <= 1'b0;
  endtask : bit_io

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask : send

  task automatic recv(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nak, r);
  endtask : recv
endmodule : wire_master

// [testbench/two_wire_slave_registers_bench.sv]
module two_wire_slave_registers_bench
  import two_wire_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  localparam int LIMIT = 20000;
  logic clk_i = 1'b0;
  logic rst_i;
  logic cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  logic ack, sda_drv, sda_oe, pins_on, irq, scl, sda_m, a;
  logic [7:0] d;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  wire logic sda_line = (sda_oe ? sda_drv : 1'b1) & sda_m;

  two_wire_slave two_wire_slave_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_drv),
    .sda_oe_o(sda_oe), .pins_i2c_o(pins_on), .irq_o(irq)
  );

  wire_master wire_master_i (
    .clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda_m)
  );

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // closing and timeout
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      complete_run();
    end
  end

  // ==========================================================
  // bus access: wait for ack with no assumed latency
  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] wd,
                    output logic [7:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    sel <= 4'h1;
    dat_w <= {24'h00_0000, wd};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    logic [7:0] r;
    wb(1'b1, ad, wd, r);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] r;
    wb(1'b0, ad, 8'h00, r);
    chk(r & m, exp);
  endtask : rd

  // ==========================================================
  // tests
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0000_0000;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_CTRL0, 8'hff, 8'h00);
    rd(ADDR_CTRL1, 8'hff, CTRL1_RST);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_CTRL0, 8'hff);
    rd(ADDR_CTRL0, 8'hff, 8'h0e);
    chk({7'h00, pins_on}, 8'h01);
    wr(ADDR_CTRL1, 8'hff);
    rd(ADDR_CTRL1, 8'hff, 8'h9b);
    wr(ADDR_CTRL1, 8'h00);
    wr(ADDR_OWN, 8'h85);
    rd(ADDR_OWN, 8'hff, 8'h84);
    rd(8'h1c, 8'hff, 8'h00);
    wr(ADDR_TMO, 8'h5a);
    rd(ADDR_TMO, 8'hff, 8'h5a);
    wr(ADDR_TMO, 8'h00);
    rd(ADDR_TMO, 8'hff, 8'h00);
    wr(ADDR_IMASK, 8'h00);
    $display("test registers done");
    // master writes, once per debounce code
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL0, {4'h0, 2'(c), 2'b10});
      rd(ADDR_CTRL0, 8'hff, {4'h0, 2'(c), 2'b10});
      wire_master_i.start();
      rd(ADDR_CTRL1, 8'ha0, 8'h20);
      if (c != 0) begin
        wire_master_i.glitch();
      end
      wire_master_i.send(8'h84, a);
      chk({7'h00, a}, 8'h00);
      rd(ADDR_CTRL1, 8'he4, 8'he0);
      wire_master_i.send({6'h16, 2'(c)}, a);
      chk({7'h00, a}, 8'h00);
      rd(ADDR_DATA, 8'hff, {6'h16, 2'(c)});
      rd(ADDR_CTRL1, 8'h80, 8'h00);
      wr(ADDR_CTRL1, 8'h08);
      wire_master_i.send(8'ha5, a);
      chk({7'h00, a}, 8'h01);
      rd(ADDR_CTRL1, 8'h80, 8'h80);
      wr(ADDR_CTRL1, 8'h00);
      wire_master_i.stop();
      rd(ADDR_CTRL1, 8'ha0, 8'h80);
      chk({7'h00, irq}, 8'h00);
    end
    $display("test receive done");
    wr(ADDR_IMASK, 8'h07);
    chk({7'h00, irq}, 8'h01);
    rd(ADDR_IST, 8'hff, 8'h07);
    chk({7'h00, irq}, 8'h00);
    $display("test interrupt done");
    // foreign address is left alone
    wr(ADDR_CTRL0, 8'h02);
    wire_master_i.start();
    wire_master_i.send(8'h86, a);
    chk({7'h00, a}, 8'h01);
    rd(ADDR_CTRL1, 8'h40, 8'h00);
    wire_master_i.stop();
    $display("test mismatch done");
    // master reads; same byte reloaded after an ack
    wr(ADDR_CTRL1, 8'h10);
    wr(ADDR_DATA, 8'hc3);
    wire_master_i.start();
    wire_master_i.send(8'h85, a);
    chk({7'h00, a}, 8'h00);
    rd(ADDR_CTRL1, 8'h44, 8'h44);
    wire_master_i.recv(1'b0, d);
    chk(d, 8'hc3);
    wire_master_i.recv(1'b1, d);
    chk(d, 8'hc3);
    rd(ADDR_CTRL1, 8'h01, 8'h01);
    wire_master_i.recv(1'b1, d);
    chk(d, 8'hff);
    chk({7'h00, sda_oe}, 8'h00);
    wire_master_i.stop();
    wr(ADDR_CTRL1, 8'h00);
    $display("test transmit done");
    // switched off: pins ignored
    wr(ADDR_CTRL0, 8'h00);
    chk({7'h00, pins_on}, 8'h00);
    wire_master_i.start();
    wire_master_i.send(8'h84, a);
    chk({7'h00, a}, 8'h01);
    rd(ADDR_CTRL1, 8'h20, 8'h00);
    wire_master_i.stop();
    $display("test disable done");
    complete_run();
  end
endmodule : two_wire_slave_registers_bench
